// [dspf_pkg.sv]
// package: constants and types for the ddr sample port fifo
package dspf_pkg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_START_LEVEL = 8'h17;
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h18;
  localparam logic [7:0] ADDR_FILL_LEVEL = 8'h19;

  localparam int START_LEVEL_LSB = 0;
  localparam int START_LEVEL_MSB = 2;
  localparam logic [2:0] START_LEVEL_RESET = 3'h4;

  localparam int STAT_REQ_BIT = 1;
  localparam int STAT_ACK_BIT = 2;
  localparam int STAT_DONE_BIT = 3;
  localparam int STAT_BY_FRAME_BIT = 4;
  localparam int STAT_BY_SOFT_BIT = 5;
  localparam int STAT_WARN_BIT = 7;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int LEVEL_W = 7;
  localparam logic [2:0] WARN_LOW = 3'h1;
  localparam logic [2:0] WARN_HIGH = 3'h7;
  localparam logic [2:0] PTR_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // port modes and capture counts
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSPF_WORD,
    DSPF_BYTE,
    DSPF_NIBBLE
  } dspf_mode_t;

  // captures (ddr edges) per channel in byte and nibble modes
  localparam logic [3:0] UNITS_BYTE = 4'h2;
  localparam logic [3:0] UNITS_NIBBLE = 4'h4;
  // frame-high captures that mean a level initialization (one period = two edges)
  localparam logic [3:0] INIT_EDGES_WORD = 4'h2;
  localparam logic [3:0] INIT_EDGES_BYTE = 4'h4;
  localparam logic [3:0] INIT_EDGES_NIBBLE = 4'h8;

  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } dspf_entry_t;

endpackage

// [dspf_port_fifo.sv]
// file: ddr sample port capture, deinterleave and eight-entry two-channel fifo
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Overview of operation
// - port accepts word (16 lanes), byte (8 lanes) and nibble (4 lanes) modes.
// - byte lanes D14,D12,D10,D8,D7,D5,D3,D1; nibble lanes D10,D8,D7,D5.
// - reference bit with data; capture data on both reference edges.
// - byte and nibble data go to I while frame high, to Q while low.
// - fifo holds eight entries of two 16-bit channels.
// - each formatted sample goes to write pointer entry, pointer then advances.
// - one entry read per data-rate tick, converter clock over interpolation ratio.
// - after frame initialization, write pointer loads start level when read reaches 0.
// - software initialization by toggling request bit 1 of status register.
// - start level is bits 2:0 of start-level register, default 4.
// - acknowledge bit 2 follows a pending request and drops after removal.
// - warning flag in status msb when fill level is 1 or 7.
// - status reports initialization method and completion.
// - level register shows write count relative to read zero as thermometer.
// - data-rate mode uses a single fifo entry.
// --------------------------------------------------------------------
module dspf_port_fifo (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] input_lane_bus,
  input wire logic data_clock_reference,
  input wire logic frame_strobe,
  input wire dspf_pkg::dspf_mode_t port_mode,
  input wire logic data_rate_mode,
  input wire logic [1:0] interp_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [15:0] sample_i,
  output logic [15:0] sample_q,
  output logic sample_valid,
  output logic fifo_warning
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [6:0] thermo(input logic [2:0] lvl);
    logic [7:0] t;
    t = (8'h01 << lvl) - 8'h01;
    return t[6:0];
  endfunction

  function automatic logic [2:0] fill_of(input logic [2:0] w, input logic [2:0] r);
    return w - r;
  endfunction

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [15:0] bus_s1_r, bus_s2_r;
  logic dci_s1_r, dci_s2_r, dci_d_r;
  logic frm_s1_r, frm_s2_r;

  // data, reference and frame share one pipeline depth so they stay aligned
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_s1_r <= 16'h0000;
      bus_s2_r <= 16'h0000;
      dci_s1_r <= 1'b0;
      dci_s2_r <= 1'b0;
      dci_d_r <= 1'b0;
      frm_s1_r <= 1'b0;
      frm_s2_r <= 1'b0;
    end else begin
      bus_s1_r <= input_lane_bus;
      bus_s2_r <= bus_s1_r;
      dci_s1_r <= data_clock_reference;
      dci_s2_r <= dci_s1_r;
      dci_d_r <= dci_s2_r;
      frm_s1_r <= frame_strobe;
      frm_s2_r <= frm_s1_r;
    end
  end

  // limitation: the reference must toggle slower than mclk/2 for each edge to be seen
  logic cap;
  assign cap = dci_s2_r ^ dci_d_r;

  logic [7:0] byte_lanes;
  logic [3:0] nib_lanes;
  assign byte_lanes = {bus_s2_r[14], bus_s2_r[12], bus_s2_r[10], bus_s2_r[8],
                       bus_s2_r[7], bus_s2_r[5], bus_s2_r[3], bus_s2_r[1]};
  assign nib_lanes = {bus_s2_r[10], bus_s2_r[8], bus_s2_r[7], bus_s2_r[5]};

  // ------------------------------------------------------------------
  // deinterleave
  // ------------------------------------------------------------------
  logic [15:0] i_sh_r, q_sh_r;
  logic [3:0] q_cnt_r;
  logic wr_req;
  logic [3:0] units;
  logic [15:0] i_nxt, q_nxt;

  assign units = (port_mode == dspf_pkg::DSPF_NIBBLE) ? dspf_pkg::UNITS_NIBBLE
                                                      : dspf_pkg::UNITS_BYTE;

  always_comb begin
    i_nxt = i_sh_r;
    q_nxt = q_sh_r;
    case (port_mode)
      dspf_pkg::DSPF_WORD: begin
        if (dci_s2_r) begin
          i_nxt = bus_s2_r;
        end else begin
          q_nxt = bus_s2_r;
        end
      end
      dspf_pkg::DSPF_BYTE: begin
        // high byte arrives first, so shifting left places it in the msbs
        if (frm_s2_r) begin
          i_nxt = {i_sh_r[7:0], byte_lanes};
        end else begin
          q_nxt = {q_sh_r[7:0], byte_lanes};
        end
      end
      dspf_pkg::DSPF_NIBBLE: begin
        if (frm_s2_r) begin
          i_nxt = {i_sh_r[11:0], nib_lanes};
        end else begin
          q_nxt = {q_sh_r[11:0], nib_lanes};
        end
      end
      default: begin
        i_nxt = i_sh_r;
        q_nxt = q_sh_r;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      i_sh_r <= 16'h0000;
      q_sh_r <= 16'h0000;
    end else if (cap) begin
      i_sh_r <= i_nxt;
      q_sh_r <= q_nxt;
    end
  end

  // a sample is complete when its last q unit is captured
  always_comb begin
    wr_req = 1'b0;
    if (cap) begin
      if (port_mode == dspf_pkg::DSPF_WORD) begin
        wr_req = ~dci_s2_r;
      end else begin
        wr_req = ~frm_s2_r && (q_cnt_r == units - 4'h1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      q_cnt_r <= 4'h0;
    end else if (cap) begin
      if (frm_s2_r || wr_req) begin
        q_cnt_r <= 4'h0;
      end else begin
        q_cnt_r <= q_cnt_r + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------------
  // data-rate tick from the converter clock divider
  // ------------------------------------------------------------------
  logic [2:0] div_r;
  logic [2:0] div_max;
  logic rd_tick;
  assign div_max = 3'((4'h1 << interp_sel) - 4'h1);
  assign rd_tick = (div_r >= div_max);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_r <= 3'h0;
    end else if (rd_tick) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // fifo storage and pointers
  // ------------------------------------------------------------------
  dspf_pkg::dspf_entry_t mem [dspf_pkg::FIFO_DEPTH];
  logic [2:0] wr_ptr_r, rd_ptr_r, rd_ptr_nxt;
  logic [2:0] start_level_r;
  logic init_load;
  logic frm_pend_r, sw_pend_r;

  assign rd_ptr_nxt = rd_ptr_r + 3'h1;
  // load happens on the tick that brings the read pointer to zero
  assign init_load = (frm_pend_r || sw_pend_r) && rd_tick && (rd_ptr_nxt == dspf_pkg::PTR_ZERO);

  always_ff @(posedge mclk) begin
    if (wr_req) begin
      mem[data_rate_mode ? dspf_pkg::PTR_ZERO : wr_ptr_r] <= '{i: i_nxt, q: q_nxt};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr_r <= dspf_pkg::START_LEVEL_RESET;
    end else if (data_rate_mode) begin
      wr_ptr_r <= dspf_pkg::PTR_ZERO;
    end else if (init_load) begin
      wr_ptr_r <= start_level_r;
    end else if (wr_req) begin
      wr_ptr_r <= wr_ptr_r + 3'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_ptr_r <= dspf_pkg::PTR_ZERO;
    end else if (data_rate_mode) begin
      rd_ptr_r <= dspf_pkg::PTR_ZERO;
    end else if (rd_tick) begin
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // read path does not guard pointer equality; the source must keep them apart
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sample_i <= 16'h0000;
      sample_q <= 16'h0000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= rd_tick;
      if (rd_tick) begin
        sample_i <= mem[rd_ptr_r].i;
        sample_q <= mem[rd_ptr_r].q;
      end
    end
  end

  // ------------------------------------------------------------------
  // frame-strobe initialization
  // ------------------------------------------------------------------
  logic [3:0] frm_hi_r;
  logic [3:0] init_edges;
  logic frm_init;

  always_comb begin
    case (port_mode)
      dspf_pkg::DSPF_WORD: init_edges = dspf_pkg::INIT_EDGES_WORD;
      dspf_pkg::DSPF_BYTE: init_edges = dspf_pkg::INIT_EDGES_BYTE;
      dspf_pkg::DSPF_NIBBLE: init_edges = dspf_pkg::INIT_EDGES_NIBBLE;
      default: init_edges = dspf_pkg::INIT_EDGES_WORD;
    endcase
  end

  assign frm_init = cap && frm_s2_r && (frm_hi_r == init_edges - 4'h1);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frm_hi_r <= 4'h0;
    end else if (cap) begin
      if (!frm_s2_r) begin
        frm_hi_r <= 4'h0;
      end else if (frm_hi_r != init_edges) begin
        frm_hi_r <= frm_hi_r + 4'h1;
      end
    end
  end

  // a new arm wins over the load that clears it
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frm_pend_r <= 1'b0;
    end else if (frm_init) begin
      frm_pend_r <= 1'b1;
    end else if (init_load) begin
      frm_pend_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic req_r, ack_r, done_r, by_frame_r, by_soft_r;
  logic [6:0] level_r;
  logic req_rise;

  assign req_rise = reg_wr && (reg_addr == dspf_pkg::ADDR_STATUS_CTRL)
                    && reg_wdata[dspf_pkg::STAT_REQ_BIT] && !req_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      start_level_r <= dspf_pkg::START_LEVEL_RESET;
    end else if (reg_wr && (reg_addr == dspf_pkg::ADDR_START_LEVEL)) begin
      start_level_r <= reg_wdata[dspf_pkg::START_LEVEL_MSB:dspf_pkg::START_LEVEL_LSB];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      req_r <= 1'b0;
    end else if (reg_wr && (reg_addr == dspf_pkg::ADDR_STATUS_CTRL)) begin
      req_r <= reg_wdata[dspf_pkg::STAT_REQ_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sw_pend_r <= 1'b0;
    end else if (req_rise) begin
      sw_pend_r <= 1'b1;
    end else if (init_load) begin
      sw_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      done_r <= 1'b0;
      by_frame_r <= 1'b0;
      by_soft_r <= 1'b0;
    end else if (init_load) begin
      done_r <= 1'b1;
      by_frame_r <= frm_pend_r;
      by_soft_r <= sw_pend_r;
    end else if (frm_init || req_rise) begin
      done_r <= 1'b0;
    end
  end

  // snapshot of the write pointer whenever the read pointer sits at zero
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      level_r <= thermo(dspf_pkg::START_LEVEL_RESET);
    end else if (rd_ptr_r == dspf_pkg::PTR_ZERO) begin
      level_r <= thermo(wr_ptr_r);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fifo_warning <= 1'b0;
    end else begin
      fifo_warning <= (fill_of(wr_ptr_r, rd_ptr_r) == dspf_pkg::WARN_LOW)
                   || (fill_of(wr_ptr_r, rd_ptr_r) == dspf_pkg::WARN_HIGH);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        dspf_pkg::ADDR_START_LEVEL: reg_rdata <= {5'h00, start_level_r};
        dspf_pkg::ADDR_STATUS_CTRL: reg_rdata <= {fifo_warning, 1'b0, by_soft_r, by_frame_r,
                                                  done_r, ack_r, req_r, 1'b0};
        dspf_pkg::ADDR_FILL_LEVEL: reg_rdata <= {1'b0, level_r};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// [dspf_port_fifo_asserts.sv]
// checker: port-level assertions for the ddr sample port fifo
`timescale 1ns/1ps
module dspf_port_fifo_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic data_rate_mode,
  input wire logic [1:0] interp_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic fifo_warning
);
  logic [2:0] lvl_sh_r;
  logic req_sh_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // --
  // shadows of the writable fields
  // --
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      lvl_sh_r <= 3'h4;
      req_sh_r <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h17) begin
      lvl_sh_r <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == 8'h18) begin
      req_sh_r <= reg_wdata[1];
    end
  end
  reset_values_a: assert property (disable iff (1'b0) !resetn |=>
    reg_rdata == 8'h00 && !sample_valid && !fifo_warning) else $error("reset values wrong");
  unmapped_read_a: assert property (reg_rd && !(reg_addr inside {8'h17, 8'h18, 8'h19})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  level_thermo_a: assert property (reg_rd && reg_addr == 8'h19 |=>
    (reg_rdata & (reg_rdata + 8'h01)) == 8'h00 && !reg_rdata[7]) else $error("level code bad");
  start_level_a: assert property (reg_rd && reg_addr == 8'h17 |=>
    reg_rdata[2:0] == $past(lvl_sh_r)) else $error("start level readback wrong");
  ack_follow_a: assert property (reg_rd && reg_addr == 8'h18 && !$past(reg_wr) |=>
    reg_rdata[2:1] == {2{$past(req_sh_r)}}) else $error("request or ack wrong");
  status_resv_a: assert property (reg_rd && reg_addr == 8'h18 |=>
    reg_rdata[6] == 1'b0 && reg_rdata[0] == 1'b0) else $error("status spare bits set");
  valid_pulse_a: assert property (sample_valid && interp_sel != 2'h0 |=> !sample_valid)
    else $error("sample valid too long");
  read_rate_a: assert property (sample_valid && interp_sel == 2'h3 |=>
    !sample_valid [*7] ##1 sample_valid) else $error("read tick spacing wrong");
  rate_mode_warn_a: assert property (data_rate_mode [*4] |-> !fifo_warning)
    else $error("warning in single entry mode");
endmodule
bind dspf_port_fifo dspf_port_fifo_asserts dspf_port_fifo_asserts_i (.mclk(mclk),
  .resetn(resetn), .data_rate_mode(data_rate_mode), .interp_sel(interp_sel),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sample_valid(sample_valid), .fifo_warning(fifo_warning));

// [dspf_port_fifo_tb.sv]
// testbench: register and sample stream tests for the ddr sample port fifo
`timescale 1ns/1ps
module dspf_port_fifo_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic rate_mode = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [1:0] sel = 2'h0;
  dspf_pkg::dspf_mode_t mode = dspf_pkg::DSPF_WORD;
  logic [15:0] lanes, sample_i, sample_q;
  logic dref, frame, sample_valid, fifo_warning;
  logic [7:0] reg_rdata, rv;
  logic [7:0] lv[3] = '{8'h00, 8'h07, 8'h02};
  int bad_count = 0, n_checks = 0, hits = 0, warn_n = 0;
  always #2.5 mclk = ~mclk;
  dspf_port_fifo dspf_port_fifo_i (.mclk(mclk), .resetn(resetn), .input_lane_bus(lanes),
    .data_clock_reference(dref), .frame_strobe(frame), .port_mode(mode),
    .data_rate_mode(rate_mode), .interp_sel(sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_i(sample_i), .sample_q(sample_q), .sample_valid(sample_valid),
    .fifo_warning(fifo_warning));
  dspf_src_model dspf_src_model_i (.mclk(mclk), .lanes(lanes), .dref(dref), .frame(frame));
  function automatic logic [15:0] ev(input int k, input logic [15:0] b, input logic [15:0] s);
    return b + 16'(k) * s;
  endfunction
  // --
  // tasks
  // --
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    rv = reg_rdata;
    if (m != 8'h00) chk($sformatf("reg %h", a), {8'h00, e & m}, {8'h00, rv & m});
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    rd(8'h18, 8'h00, 8'h00);
    for (int i = 0; i < 40 && (rv & m) !== v; i++) rd(8'h18, 8'h00, 8'h00);
    chk("status poll", {8'h00, v}, {8'h00, rv & m});
  endtask
  task automatic restart(input dspf_pkg::dspf_mode_t m, input logic [1:0] s);
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    mode = m;
    sel = s;
    rate_mode = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
  endtask
  // counts high cycles of the warning flag or of the sample strobe over a window
  task automatic count_hi(input string nm, input logic use_valid, input int e);
    warn_n = 0;
    repeat (64) begin
      @(posedge mclk);
      #1;
      if ((use_valid ? sample_valid : fifo_warning) === 1'b1) warn_n++;
    end
    chk(nm, 16'(e), 16'(warn_n));
  endtask
  // byte and nibble write slower than the reads, so outputs may repeat
  task automatic stream(input dspf_pkg::dspf_mode_t m);
    restart(m, 2'h3);
    for (int j = 0; j < 21; j++)
      if (j < 9) dspf_src_model_i.send(16'h0000, 16'h0000, m, j == 0);
      else dspf_src_model_i.send(ev(j - 9, 16'hA5C3, 16'h1357),
        ev(j - 9, 16'h3C5A, 16'h2468), m, 1'b0);
    dspf_src_model_i.park();
    repeat (150) @(posedge mclk);
    chk("samples in order", 16'h000C, 16'(hits));
    rd(8'h18, 8'h38, 8'h18);
    $display("test stream mode %0d done", m);
  endtask
  always @(posedge mclk)
    if (!resetn) hits <= 0;
    else if (sample_valid === 1'b1 && sample_i === ev(hits, 16'hA5C3, 16'h1357)
      && sample_q === ev(hits, 16'h3C5A, 16'h2468)) hits <= hits + 1;
  initial begin
    #100us;
    bad_count++;
    give_verdict();
  end
  initial begin
    restart(dspf_pkg::DSPF_WORD, 2'h0);
    rd(8'h17, 8'h07, 8'h04);
    rd(8'h18, 8'h7F, 8'h00);
    rd(8'h19, 8'hFF, 8'h0F);
    rd(8'h20, 8'hFF, 8'h00);
    wr(8'h19, 8'hFF);
    rd(8'h19, 8'hFF, 8'h0F);
    foreach (lv[n]) begin
      wr(8'h17, lv[n]);
      rd(8'h17, 8'h07, lv[n]);
      wr(8'h18, 8'h02);
      poll(8'h04, 8'h04);
      wr(8'h18, 8'h00);
      poll(8'h04, 8'h00);
      poll(8'h08, 8'h08);
      repeat (20) @(posedge mclk);
      rd(8'h18, 8'h3A, 8'h28);
      rd(8'h19, 8'hFF, (8'h01 << lv[n]) - 8'h01);
    end
    count_hi("warning cycles", 1'b0, 16);
    rate_mode = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    count_hi("warning cycles", 1'b0, 0);
    rd(8'h19, 8'hFF, 8'h00);
    restart(dspf_pkg::DSPF_WORD, 2'h1);
    count_hi("valid pulses", 1'b1, 32);
    restart(dspf_pkg::DSPF_WORD, 2'h2);
    count_hi("valid pulses", 1'b1, 16);
    $display("test registers done");
    stream(dspf_pkg::DSPF_WORD);
    stream(dspf_pkg::DSPF_BYTE);
    stream(dspf_pkg::DSPF_NIBBLE);
    give_verdict();
  end
endmodule

// [dspf_src_model.sv]
// model: sample source driving lanes, reference and frame
`timescale 1ns/1ps
module dspf_src_model (
  input wire logic mclk,
  output logic [15:0] lanes,
  output logic dref,
  output logic frame
);
  // four cycles per edge keeps edges well apart for the pin synchronizers
  localparam int HALF_CYC = 4;
  int byte_lane[8] = '{14, 12, 10, 8, 7, 5, 3, 1};
  int nib_lane[4] = '{10, 8, 7, 5};
  initial begin
    lanes = 16'h0000;
    dref = 1'b0;
    frame = 1'b0;
  end
  // unused lanes flip so stale bits never look valid
  task automatic put(input logic [15:0] v, input int w, input logic f);
    logic [15:0] nb;
    nb = ~lanes;
    for (int b = 0; b < w; b++) begin
      if (w == 16) nb[b] = v[b];
      else if (w == 8) nb[byte_lane[7-b]] = v[b];
      else nb[nib_lane[3-b]] = v[b];
    end
    repeat (HALF_CYC) @(posedge mclk);
    #1;
    lanes = nb;
    dref = ~dref;
    frame = f;
  endtask
  task automatic send(input logic [15:0] si, input logic [15:0] sq,
    input dspf_pkg::dspf_mode_t m, input logic ini);
    int w;
    w = (m == dspf_pkg::DSPF_WORD) ? 16 : (m == dspf_pkg::DSPF_BYTE) ? 8 : 4;
    for (int u = 16 / w - 1; u >= 0; u--) put(si >> (u * w), w, ini || w != 16);
    for (int u = 16 / w - 1; u >= 0; u--) put(sq >> (u * w), w, ini);
  endtask
  // the last unit must stand a full slot before the lanes are let go
  task automatic park();
    repeat (HALF_CYC) @(posedge mclk);
    #1;
    lanes = ~lanes;
  endtask
endmodule
